// *** block_move_pkg.sv ***
package block_move_pkg;

	localparam int ADDR_W = 12;
	localparam int COUNT_W = 8;
	localparam int BYTE_W = 8;
	localparam logic [12:0] MEM_BYTES = 13'h0300;

	localparam int STAT_HI_BUSY = 0;
	localparam int STAT_LO_BUSY = 1;
	localparam int STAT_RUNNING = 2;
	localparam int STAT_OVERFLOW = 3;
	localparam int STAT_ADDR_ERR = 4;
	localparam int STAT_BAD_OP = 5;

	localparam logic PRIO_LOW = 1'b0;
	localparam logic PRIO_HIGH = 1'b1;

	typedef enum logic [2:0] {
		OP_TXQ_COPY,
		OP_COPY,
		OP_COPY_REV,
		OP_XOR
	} opcode_t;

	typedef struct packed {
		logic [2:0] op;
		logic prio;
		logic [COUNT_W-1:0] count;
		logic [ADDR_W-1:0] src;
		logic [ADDR_W-1:0] dst;
	} cmd_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic low_done;
		logic high_done;
		logic prio_conflict;
		logic txq_overflow;
		logic addr_range;
		logic bad_operand;
	} events_t;

endpackage : block_move_pkg

// *** two_entry_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] rd_q;
	logic [PTR_W:0] used_q;
	logic push;
	logic pop;

	assign in_ready_out = (used_q != (PTR_W+1)'(DEPTH));
	assign out_valid_out = (used_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_ff @(posedge clock_in)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			wr_q <= '0;
			rd_q <= '0;
			used_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= (wr_q == PTR_W'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop)
			begin
				rd_q <= (rd_q == PTR_W'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			used_q <= used_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

endmodule : two_entry_buffer
`default_nettype wire

// *** memory_block_move_engine.sv ***
// Behaviour
// - a queue copy appends C bytes read from address A to the queue.
// - during a queue copy the current transmit-queue fill is offered.
// - the priority bit picks low (0) or high (1) as the run level.
// - a queue copy that meets a full queue early raises the overflow event.
// - an early-stopped queue copy shows the bytes still to move.
// - each finished instruction raises the done event of its level.
// - an instruction for a busy level raises the priority conflict event.
// - a block copy moves C bytes from A to E in the same order.
// - a reversed copy writes the byte at A+n to E+C-1-n.
// - a block xor writes A[n] xor E[n] back over E[n] for C bytes.
// - the xor treats both operands as C-byte blocks at A and E.
`timescale 1ns/1ps
`default_nettype none
module memory_block_move_engine
	import block_move_pkg::*;
#(
	parameter logic [12:0] MEM_SIZE = MEM_BYTES
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// instruction port from the serial front end
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire block_move_pkg::cmd_t cmd_in,
	// status toward the serial front end
	output logic [7:0] status_byte_out,
	output logic [7:0] txq_level_out,
	output logic [7:0] remaining_out,
	// buffer memory, read data valid one cycle after rd
	output block_move_pkg::mem_req_t mem_req_out,
	input wire logic [7:0] mem_rdata_in,
	// transmit queue
	input wire logic [7:0] txq_fill_in,
	input wire logic txq_full_in,
	output logic txq_valid_out,
	input wire logic txq_ready_in,
	output logic [7:0] txq_data_out,
	// one-cycle event pulses
	output block_move_pkg::events_t events_out
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_CHECK,
		S_WAIT_A,
		S_TAKE_A,
		S_WAIT_E,
		S_TAKE_E,
		S_PUT,
		S_NEXT
	} state_t;
	state_t state_q;
	cmd_t slot_q [2];
	logic [1:0] busy_q;
	cmd_t cur_q;
	logic [COUNT_W-1:0] idx_q;
	logic [BYTE_W-1:0] byte_q;
	logic [COUNT_W-1:0] remaining_q;
	logic done_q, overflow_q, addr_err_q, bad_op_q;
	mem_req_t mem_q;
	events_t events_q;
	logic [7:0] status_q;
	logic [7:0] level_q;
	logic accept, conflict, is_txq, is_xor, range_bad, op_bad, last;
	logic buf_in_valid, buf_in_ready;
	logic [12:0] src_end;
	logic [12:0] dst_end;
	logic [ADDR_W-1:0] dst_addr;
	assign cmd_ready_out = 1'b1;
	// a busy level refuses the new instruction instead of queueing it
	assign conflict = cmd_valid_in && busy_q[cmd_in.prio];
	assign accept = cmd_valid_in && !busy_q[cmd_in.prio];

	assign is_txq = (cur_q.op == 3'(OP_TXQ_COPY));
	assign is_xor = (cur_q.op == 3'(OP_XOR));
	assign op_bad = (cur_q.op > 3'(OP_XOR));
	assign src_end = {1'b0, cur_q.src} + {5'h00, cur_q.count};
	assign dst_end = {1'b0, cur_q.dst} + {5'h00, cur_q.count};
	assign range_bad = (src_end > MEM_SIZE) ||
		(!is_txq && (dst_end > MEM_SIZE));
	assign last = (idx_q == cur_q.count - 8'h01);
	assign dst_addr = (cur_q.op == 3'(OP_COPY_REV)) ?
		cur_q.dst + ADDR_W'(cur_q.count) - 12'h001 - ADDR_W'(idx_q) :
		cur_q.dst + ADDR_W'(idx_q);
	assign buf_in_valid = (state_q == S_PUT) && is_txq && !txq_full_in;
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			busy_q <= 2'h0;
			slot_q[0] <= '0;
			slot_q[1] <= '0;
		end
		else
		begin
			if (accept)
			begin
				slot_q[cmd_in.prio] <= cmd_in;
			end
			for (int p = 0; p < 2; p++)
			begin
				if (accept && cmd_in.prio == 1'(p))
				begin
					busy_q[p] <= 1'b1;
				end
				else if (done_q && cur_q.prio == 1'(p))
				begin
					busy_q[p] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			state_q <= S_IDLE;
			cur_q <= '0;
			idx_q <= 8'h00;
			byte_q <= 8'h00;
			mem_q <= '0;
			remaining_q <= 8'h00;
			done_q <= 1'b0;
			overflow_q <= 1'b0;
			addr_err_q <= 1'b0;
			bad_op_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			overflow_q <= 1'b0;
			addr_err_q <= 1'b0;
			bad_op_q <= 1'b0;
			mem_q <= '0;
			unique case (state_q)
				S_IDLE:
				begin
					// high level is served first; a running move is not preempted
					if ((busy_q != 2'h0) && !done_q)
					begin
						cur_q <= slot_q[busy_q[PRIO_HIGH]];
						state_q <= S_CHECK;
					end
					idx_q <= 8'h00;
				end
				S_CHECK:
				begin
					remaining_q <= 8'h00;
					bad_op_q <= op_bad;
					addr_err_q <= !op_bad && range_bad;
					if (op_bad || range_bad || cur_q.count == 8'h00)
					begin
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
					else
					begin
						mem_q.rd <= 1'b1;
						mem_q.addr <= cur_q.src;
						state_q <= S_WAIT_A;
					end
				end
				S_WAIT_A:
				begin
					state_q <= S_TAKE_A;
				end
				S_TAKE_A:
				begin
					byte_q <= mem_rdata_in;
					if (is_xor)
					begin
						mem_q.rd <= 1'b1;
						mem_q.addr <= dst_addr;
						state_q <= S_WAIT_E;
					end
					else
					begin
						state_q <= S_PUT;
					end
				end
				S_WAIT_E:
				begin
					state_q <= S_TAKE_E;
				end
				S_TAKE_E:
				begin
					byte_q <= byte_q ^ mem_rdata_in;
					state_q <= S_PUT;
				end
				S_PUT:
				begin
					if (is_txq)
					begin
						if (txq_full_in)
						begin
							overflow_q <= 1'b1;
							remaining_q <= cur_q.count - idx_q;
							done_q <= 1'b1;
							state_q <= S_IDLE;
						end
						else if (buf_in_ready)
						begin
							state_q <= S_NEXT;
						end
					end
					else
					begin
						mem_q.wr <= 1'b1;
						mem_q.addr <= dst_addr;
						mem_q.wdata <= byte_q;
						state_q <= S_NEXT;
					end
				end
				S_NEXT:
				begin
					if (last)
					begin
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
					else
					begin
						mem_q.rd <= 1'b1;
						mem_q.addr <= cur_q.src + ADDR_W'(idx_q) + 12'h001;
						idx_q <= idx_q + 8'h01;
						state_q <= S_WAIT_A;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			events_q <= '0;
		end
		else
		begin
			events_q.low_done <= done_q && (cur_q.prio == PRIO_LOW);
			events_q.high_done <= done_q && (cur_q.prio == PRIO_HIGH);
			events_q.prio_conflict <= conflict;
			events_q.txq_overflow <= overflow_q;
			events_q.addr_range <= addr_err_q;
			events_q.bad_operand <= bad_op_q;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			status_q <= 8'h00;
			level_q <= 8'h00;
		end
		else
		begin
			level_q <= txq_fill_in;
			status_q[STAT_HI_BUSY] <= busy_q[PRIO_HIGH];
			status_q[STAT_LO_BUSY] <= busy_q[PRIO_LOW];
			status_q[STAT_RUNNING] <= (state_q != S_IDLE);
			// last-result flags hold until the next instruction finishes
			if (done_q)
			begin
				status_q[STAT_OVERFLOW] <= overflow_q;
				status_q[STAT_ADDR_ERR] <= addr_err_q;
				status_q[STAT_BAD_OP] <= bad_op_q;
			end
			status_q[7:6] <= 2'h0;
		end
	end

	two_entry_buffer #(
		.WIDTH(BYTE_W),
		.DEPTH(2)
	) txq_buffer (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.in_valid_in(buf_in_valid),
		.in_ready_out(buf_in_ready),
		.in_data_in(byte_q),
		.out_valid_out(txq_valid_out),
		.out_ready_in(txq_ready_in),
		.out_data_out(txq_data_out)
	);
	assign mem_req_out = mem_q;
	assign events_out = events_q;
	assign status_byte_out = status_q;
	assign txq_level_out = level_q;
	assign remaining_out = remaining_q;
endmodule : memory_block_move_engine
`default_nettype wire

// *** mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_model
	import block_move_pkg::*;
#(
	parameter int CAP = 3
) (
	// clock
	input wire logic clock_in,
	// buffer memory
	input wire block_move_pkg::mem_req_t req_in,
	output logic [7:0] rdata_out,
	// transmit queue sink
	input wire logic valid_in,
	input wire logic [7:0] data_in,
	input wire logic stall_in,
	output logic ready_out,
	output logic full_out,
	output logic [7:0] fill_out
);
	logic [7:0] mem_q [4096];
	logic [7:0] q [$];
	assign ready_out = !stall_in;
	assign full_out = fill_out >= 8'(CAP);
	// idle read bus toggles so a late sample never looks valid
	always @(posedge clock_in)
	begin
		rdata_out <= req_in.rd ? mem_q[req_in.addr] : ~rdata_out;
		if (req_in.wr)
			mem_q[req_in.addr] <= req_in.wdata;
		if (valid_in && ready_out)
		begin
			q.push_back(data_in);
			fill_out <= fill_out + 8'h01;
		end
	end
endmodule : mem_model
`default_nettype wire

// *** move_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module move_checker
	import block_move_pkg::*;
(
	// watched ports
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] status_byte_out,
	input wire logic [7:0] txq_level_out,
	input wire logic [7:0] txq_fill_in,
	input wire block_move_pkg::mem_req_t mem_req_out,
	input wire logic txq_valid_out,
	input wire logic txq_ready_in,
	input wire logic [7:0] txq_data_out,
	input wire block_move_pkg::events_t events_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic [2:0] since_rd_q;
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in || mem_req_out.rd)
			since_rd_q <= 3'h0;
		else if (since_rd_q != 3'h7)
			since_rd_q <= since_rd_q + 3'h1;
	end
	a_mem_one_op: assert property (!(mem_req_out.rd && mem_req_out.wr))
		else $error("memory read and write together");
	a_write_after_read: assert property (mem_req_out.wr |-> since_rd_q < 3'h6)
		else $error("memory write without a recent read");
	a_conflict_cause: assert property (events_out.prio_conflict |-> $past(cmd_valid_in))
		else $error("conflict without an offered instruction");
	a_done_one_level: assert property (!(events_out.low_done && events_out.high_done))
		else $error("both done events at once");
	a_overflow_ends: assert property (events_out.txq_overflow |->
		##[0:3] (events_out.low_done || events_out.high_done))
		else $error("overflow without done");
	a_range_no_write: assert property (events_out.addr_range |->
		!$past(mem_req_out.wr) && !$past(mem_req_out.wr, 2))
		else $error("address error after a write");
	a_level_follows: assert property ($past(rstn_in) |->
		txq_level_out == $past(txq_fill_in))
		else $error("queue level not reported");
	a_queue_hold: assert property (txq_valid_out && !txq_ready_in |=>
		txq_valid_out && $stable(txq_data_out))
		else $error("queue word lost while stalled");
	a_status_spare: assert property (status_byte_out[7:6] == 2'h0)
		else $error("status spare bits set");
	c_conflict: cover property (events_out.prio_conflict);
	c_overflow: cover property (events_out.txq_overflow);
	c_range: cover property (events_out.addr_range);
endmodule : move_checker
bind memory_block_move_engine move_checker move_checker_i (.clock_in,
	.rstn_in, .cmd_valid_in, .status_byte_out, .txq_level_out, .txq_fill_in,
	.mem_req_out, .txq_valid_out, .txq_ready_in, .txq_data_out, .events_out);
`default_nettype wire

// *** memory_block_move_engine_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module memory_block_move_engine_tb_top;
	import block_move_pkg::*;
	typedef struct packed {
		cmd_t c;
		logic [5:0] ev;
	} row_t;
	localparam int CAP = 3;
	logic clock_in, rstn_in, cmd_valid, stall, ready, txq_valid, full;
	logic txq_ready;
	logic [7:0] status_byte, remaining, rdata, txq_data, fill;
	cmd_t cmd;
	mem_req_t req;
	events_t events;
	logic [5:0] seen;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	row_t rows[13] = '{
		'{{3'h1, 1'b0, 8'h04, 12'h010, 12'h100}, 6'h20},
		'{{3'h1, 1'b1, 8'h01, 12'h2ff, 12'h000}, 6'h10},
		'{{3'h2, 1'b0, 8'h05, 12'h020, 12'h120}, 6'h20},
		'{{3'h2, 1'b1, 8'h01, 12'h030, 12'h130}, 6'h10},
		'{{3'h3, 1'b0, 8'h03, 12'h040, 12'h140}, 6'h20},
		'{{3'h3, 1'b1, 8'h02, 12'h200, 12'h2fe}, 6'h10},
		'{{3'h1, 1'b0, 8'h00, 12'h060, 12'h160}, 6'h20},
		'{{3'h0, 1'b0, 8'h03, 12'h050, 12'h000}, 6'h20},
		'{{3'h0, 1'b1, 8'h02, 12'h2fe, 12'h000}, 6'h10},
		'{{3'h0, 1'b0, 8'h06, 12'h060, 12'h000}, 6'h24},
		'{{3'h1, 1'b0, 8'h02, 12'h2ff, 12'h000}, 6'h22},
		'{{3'h2, 1'b1, 8'h02, 12'h000, 12'h2ff}, 6'h12},
		'{{3'h4, 1'b0, 8'h01, 12'h000, 12'h170}, 6'h21}};
	memory_block_move_engine memory_block_move_engine_i (.clock_in, .rstn_in,
		.cmd_valid_in(cmd_valid), .cmd_ready_out(ready), .cmd_in(cmd),
		.status_byte_out(status_byte), .txq_level_out(),
		.remaining_out(remaining), .mem_req_out(req), .mem_rdata_in(rdata),
		.txq_fill_in(fill), .txq_full_in(full), .txq_valid_out(txq_valid),
		.txq_ready_in(txq_ready), .txq_data_out(txq_data),
		.events_out(events));
	mem_model #(.CAP(CAP)) mem_model_i (.clock_in, .req_in(req),
		.rdata_out(rdata), .valid_in(txq_valid), .data_in(txq_data),
		.stall_in(stall), .ready_out(txq_ready), .full_out(full),
		.fill_out(fill));
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in)
	begin
		seen <= seen | events;
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			final_report();
		end
	end
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 13 + 7);
	endfunction : pat
	function automatic logic [7:0] mem(input int a);
		return mem_model_i.mem_q[12'(a)];
	endfunction : mem
	task automatic check(input string name, input logic [7:0] v,
		input logic [7:0] e);
		checks++;
		if (v !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, e, v);
		end
	endtask : check
	task automatic run(input cmd_t a, input cmd_t b, input int hold,
		input logic [5:0] ev);
		int n;
		for (int i = 0; i < 4096; i++)
			mem_model_i.mem_q[i] = pat(i);
		@(negedge clock_in);
		seen = '0;
		mem_model_i.q.delete();
		mem_model_i.fill_out = '0;
		@(posedge clock_in);
		cmd_valid <= 1'b1;
		cmd <= a;
		stall <= hold > 0;
		if (b.op != 3'h7)
		begin
			@(posedge clock_in);
			cmd <= b;
		end
		@(posedge clock_in);
		cmd_valid <= 1'b0;
		repeat (hold) @(posedge clock_in);
		stall <= 1'b0;
		n = 0;
		while ((seen[5:4] & ev[5:4]) != ev[5:4] && n < 500)
		begin
			@(posedge clock_in);
			n++;
		end
		repeat (3) @(posedge clock_in);
		check("events", 8'(seen), 8'(ev));
	endtask : run
	task automatic verify(input cmd_t c, input logic [5:0] ev);
		logic [7:0] v;
		int k;
		// rejected instructions move nothing, so only untouched bytes at E are compared
		k = (ev[1] || ev[0]) ? 0 :
			((c.op == 3'h0 && ev[2]) ? CAP : int'(c.count));
		if (ev[1] || ev[0])
			check("untouched", mem(c.dst), pat(c.dst));
		for (int n = 0; n < k; n++)
		begin
			v = pat(c.src + n);
			case (c.op)
				3'h0: check("queue", mem_model_i.q[n], v);
				3'h1: check("copy", mem(c.dst + n), v);
				3'h2: check("rev", mem(c.dst + c.count - 1 - n), v);
				default: check("xor", mem(c.dst + n), v ^ pat(c.dst + n));
			endcase
		end
		if (c.op == 3'h0)
			check("qsize", 8'(mem_model_i.q.size()), 8'(k));
		else
			check("edge", mem(c.dst + c.count), pat(c.dst + c.count));
		if (ev[2])
		begin
			check("left", remaining, c.count - 8'(CAP));
			check("ovf", 8'(status_byte[3]), 8'h01);
		end
	endtask : verify
	task automatic do_reset;
		@(posedge clock_in);
		rstn_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		check("status", status_byte, 8'h00);
		check("flags", {remaining[5:0], txq_valid, ready}, 8'h01);
		@(posedge clock_in);
		rstn_in <= 1'b1;
	endtask : do_reset
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	initial
	begin
		rstn_in = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		stall = 1'b0;
		do_reset();
		foreach (rows[r])
		begin
			run(rows[r].c, '1, 0, rows[r].ev);
			verify(rows[r].c, rows[r].ev);
		end
		// same level twice back to back: second is dropped
		run({3'h1, 1'b0, 8'h02, 12'h010, 12'h100},
			{3'h1, 1'b0, 8'h01, 12'h020, 12'h110}, 0, 6'h28);
		verify({3'h1, 1'b0, 8'h02, 12'h010, 12'h100}, 6'h20);
		// one low then one high back to back: both levels run
		run({3'h1, 1'b0, 8'h02, 12'h010, 12'h100},
			{3'h2, 1'b1, 8'h03, 12'h020, 12'h120}, 0, 6'h30);
		verify({3'h2, 1'b1, 8'h03, 12'h020, 12'h120}, 6'h10);
		// receiver stalls long enough to fill the two-entry buffer
		run({3'h0, 1'b1, 8'h03, 12'h050, 12'h000}, '1, 30, 6'h10);
		verify({3'h0, 1'b1, 8'h03, 12'h050, 12'h000}, 6'h10);
		do_reset();
		final_report();
	end
endmodule : memory_block_move_engine_tb_top
`default_nettype wire
